/* File: logic/pm_i2c_target.sv */
// Purpose: I2C target giving byte access to the register file
// Assumes: scl and sda are pins from outside the clock domain
// Notes:   first written byte sets the pointer, pointer auto-increments
`timescale 1ns/1ps
`default_nettype none
`include "pm_regs.svh"
module pm_i2c_target
  import pm_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // register side
  output pm_bytewr_t      wr,
  output logic [7:0]      rd_addr,
  input  wire logic [7:0] rd_data
);

  pm_i2c_q_t q;
  pm_i2c_q_t n;
  logic      rise;
  logic      fall;
  logic      start;
  logic      stop;

  always_comb begin
    n = q;
    n.wr.stb = 1'b0;
    // a change only counts once two later stages agree
    n.scl_s = {q.scl_s[1:0], scl_in}; // R11
    n.sda_s = {q.sda_s[1:0], sda_in};
    if (q.scl_s[1] == q.scl_s[2]) n.scl_f = q.scl_s[2];
    if (q.sda_s[1] == q.sda_s[2]) n.sda_f = q.sda_s[2];
    rise  = n.scl_f & ~q.scl_f;
    fall  = ~n.scl_f & q.scl_f;
    start = q.scl_f & n.scl_f & q.sda_f & ~n.sda_f;
    stop  = q.scl_f & n.scl_f & ~q.sda_f & n.sda_f;
    if (start) begin
      n.st   = PM_I_ADDR;
      n.bits = 4'h0;
      n.oe   = 1'b0;
      n.drv  = 1'b0;
    end else if (stop) begin
      n.st = PM_I_IDLE;
      n.oe = 1'b0;
    end else begin
      unique case (q.st)
        PM_I_IDLE: begin
        end
        PM_I_ADDR, PM_I_WR: begin
          if (rise) begin
            n.sh   = {q.sh[6:0], n.sda_f};
            n.bits = q.bits + 4'h1;
            if (q.bits == 4'h7) begin
              if (q.st == PM_I_ADDR) begin
                n.st    = (n.sh[7:1] == `PM_I2C_DEV) ? PM_I_AACK : PM_I_IDLE;
                n.rw    = n.sh[0];
                n.first = 1'b1;
              end else begin
                n.st    = PM_I_WACK;
                n.first = 1'b0;
                if (q.first) begin
                  n.ptr = n.sh;
                end else begin
                  n.wr  = '{stb: 1'b1, addr: q.ptr, data: n.sh}; // R11
                  n.ptr = q.ptr + 8'h01;
                end
              end
            end
          end
        end
        PM_I_AACK, PM_I_WACK: begin
          if (fall) begin
            if (!q.drv) begin
              n.drv = 1'b1;
              n.oe  = 1'b1;
            end else begin
              n.drv  = 1'b0;
              n.bits = 4'h0;
              if (q.st == PM_I_AACK && q.rw) begin
                n.st = PM_I_RD;
                n.sh = rd_data;
                n.oe = ~rd_data[7];
              end else begin
                n.st = PM_I_WR;
                n.oe = 1'b0;
              end
            end
          end
        end
        PM_I_RD: begin
          if (fall) begin
            n.bits = q.bits + 4'h1;
            n.sh   = {q.sh[6:0], 1'b0};
            n.oe   = (q.bits == 4'h7) ? 1'b0 : ~q.sh[6];
            if (q.bits == 4'h7) n.st = PM_I_RACK;
          end
        end
        PM_I_RACK: begin
          if (rise) begin
            // a nack ends the read; wait for stop or start
            if (n.sda_f) n.st = PM_I_IDLE;
            else begin
              n.ptr = q.ptr + 8'h01;
              n.drv = 1'b1;
            end
          end else if (fall && q.drv) begin
            n.drv  = 1'b0;
            n.st   = PM_I_RD;
            n.bits = 4'h0;
            n.sh   = rd_data;
            n.oe   = ~rd_data[7];
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q       <= '0;
      q.scl_s <= 3'h7;
      q.sda_s <= 3'h7;
      q.scl_f <= 1'b1;
      q.sda_f <= 1'b1;
      q.st    <= PM_I_IDLE;
    end else begin
      q <= n;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = q.oe;
  assign wr      = q.wr;
  assign rd_addr = q.ptr;

endmodule // pm_i2c_target
`default_nettype wire

/* File: logic/pm_measure_ctrl.sv */
// Purpose: proximity measurement sequencer, threshold interrupt and register file
// Assumes: analog front end answers conv_start with one adc.done pulse
// Notes:   registers reachable over APB and over I2C
//
// Our own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pm_regs.svh"
// Notes on behaviour
// [R1] each measurement emits the programmed pulse count, 1 to 255
// [R2] pulses repeat every 16 us, sink on for 7.2 us
// [R3] interrupt pin asserts as a level and holds until cleared
// [R4] result above upper or below lower threshold is out of range
// [R5] interrupt only after programmed consecutive out-of-range results; in-range restarts
// [R6] interrupt pin is active-low open drain, never driven high
// [R7] saturation of the front end sets a readable status bit
// [R8] with sleep-after-interrupt selected, block sleeps once interrupt raised
// [R9] optional programmable wait between measurements, 2.7 ms steps
// [R10] software offset is subtracted from each raw result
// [R11] register access through an I2C fast-mode target, up to 400 kbit/s
// [R12] host clears pending interrupt by write; count restarts
module pm_measure_ctrl
  import pm_pkg::*;
#(
  parameter logic [19:0] WAIT_STEP_CYC = 20'(`PM_WAIT_STEP_NS / `PM_CLK_NS)
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // i2c pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // analog front end
  input  wire pm_adc_t     adc,
  output logic             conv_start,
  output logic             led_current_sink,
  // interrupt
  output logic             int_out,
  output logic             int_oe,
  output logic             irq
);

  // ****************************************
  // timing
  // ****************************************
  localparam logic [11:0] PERIOD_CYC = 12'(`PM_LED_PERIOD_NS / `PM_CLK_NS);
  localparam logic [11:0] ON_CYC     = 12'((`PM_LED_ON_NS + `PM_CLK_NS - 1) / `PM_CLK_NS);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd, logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  function automatic logic [32:0] rd_word(pm_core_t s, logic [7:0] a);
    logic [32:0] r;
    r = '0;
    unique case (a)
      `PM_CTRL_ADR:  r[4:0]  = s.ctrl;
      `PM_PULSE_ADR: r[7:0]  = s.pulses;
      `PM_WAIT_ADR:  r[7:0]  = s.wtime;
      `PM_LTHR_ADR:  r[15:0] = s.lthr;
      `PM_HTHR_ADR:  r[15:0] = s.hthr;
      `PM_OFFS_ADR:  r[7:0]  = s.offs;
      `PM_PERS_ADR:  r[3:0]  = s.pers;
      `PM_DATA_ADR:  r[15:0] = s.data;
      `PM_STAT_ADR: begin
        r[1:0]        = s.stat; // R7
        r[`PM_ST_SLEEP] = (s.st == PM_SLEEP);
        r[`PM_ST_BUSY]  = (s.st != PM_IDLE);
      end
      `PM_MASK_ADR:  r[1:0]  = s.mask;
      default:       r[32]   = 1'b1;
    endcase
    return r;
  endfunction

  function automatic logic [15:0] sub_offs(logic [15:0] c, logic [7:0] o);
    return (c > {8'h00, o}) ? (c - {8'h00, o}) : 16'h0000;
  endfunction

  // ****************************************
  // state and i2c target
  // ****************************************
  pm_core_t    q;
  pm_core_t    n;
  pm_bytewr_t  i2c_wr;
  logic [7:0]  i2c_ptr;
  logic [32:0] i2c_full;
  logic [31:0] i2c_word;
  logic [7:0]  i2c_rd;

  pm_i2c_target u_i2c (
    .clk     (clk),
    .rst     (rst),
    .scl_in  (scl_in),
    .sda_in  (sda_in),
    .sda_out (sda_out),
    .sda_oe  (sda_oe),
    .wr      (i2c_wr),
    .rd_addr (i2c_ptr),
    .rd_data (i2c_rd)
  );

  assign i2c_full = rd_word(q, {i2c_ptr[7:2], 2'b00});
  assign i2c_word = i2c_full[31:0];
  assign i2c_rd   = i2c_word[8*i2c_ptr[1:0] +: 8];

  logic        we;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [3:0]  be;
  logic [32:0] rw;
  logic [32:0] ow;
  logic [31:0] mw;
  logic [1:0]  clr;
  logic [1:0]  set;
  logic [15:0] res;
  logic [3:0]  req;
  logic        adc_eval;
  logic        out;
  logic        raise;
  logic [11:0] wbase;
  logic [7:0]  npulse;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = q;
    n.conv_start = 1'b0;
    // apb takes the port; an i2c byte landing the same cycle is lost
    we = 1'b0;
    wa = '0;
    wd = '0;
    be = '0;
    if (psel && penable && pwrite) begin
      we = 1'b1;
      wa = paddr;
      wd = pwdata;
      be = 4'hF;
    end else if (i2c_wr.stb) begin
      we = 1'b1; // R11
      wa = {i2c_wr.addr[7:2], 2'b00};
      wd = {4{i2c_wr.data}};
      be = 4'h1 << i2c_wr.addr[1:0];
    end
    // apb answer captured in setup phase
    if (psel && !penable) begin
      rw        = rd_word(q, paddr);
      n.prdata  = pwrite ? 32'h0000_0000 : rw[31:0];
      n.pslverr = rw[32];
    end else begin
      rw = '0;
    end
    // merge into the current word, so untouched byte lanes keep their value
    ow = rd_word(q, wa);
    mw = merge(ow[31:0], wd, be);
    if (we) begin
      unique case (wa)
        `PM_CTRL_ADR:  n.ctrl   = pm_ctrl_t'(mw[4:0]);
        `PM_PULSE_ADR: n.pulses = mw[7:0];
        `PM_WAIT_ADR:  n.wtime  = mw[7:0];
        `PM_LTHR_ADR:  n.lthr   = mw[15:0];
        `PM_HTHR_ADR:  n.hthr   = mw[15:0];
        `PM_OFFS_ADR:  n.offs   = mw[7:0];
        `PM_PERS_ADR:  n.pers   = mw[3:0];
        `PM_MASK_ADR:  n.mask   = mw[1:0];
        default: begin
        end
      endcase
    end
    clr = (we && wa == `PM_STAT_ADR && be[0]) ? wd[1:0] : 2'b00;

    // measurement evaluation
    npulse   = (q.pulses == 8'h00) ? 8'h01 : q.pulses;
    adc_eval = (q.st == PM_CONV) && adc.done;
    res      = sub_offs(adc.count, q.offs); // R10
    out      = (res > q.hthr) || (res < q.lthr); // R4
    req      = (q.pers == 4'h0) ? 4'h1 : q.pers;
    raise    = adc_eval && out && ({1'b0, q.pcnt} + 5'h01 >= {1'b0, req}); // R5
    set      = {adc_eval && adc.sat, raise}; // R7
    wbase    = {4'h0, q.wtime} + 12'h001;

    if (adc_eval) begin
      n.data = res;
      n.pcnt = !out ? 4'h0 : (q.pcnt == 4'hF) ? 4'hF : q.pcnt + 4'h1; // R5
    end
    // set wins over a clear in the same cycle
    if (clr[`PM_ST_PROX] && q.stat[`PM_ST_PROX] && !adc_eval) n.pcnt = 4'h0; // R12
    n.stat = (q.stat & ~clr) | set; // R3

    n.led = 1'b0;
    unique case (q.st)
      PM_IDLE: begin
        if (q.ctrl.en) begin
          n.st    = PM_BURST;
          n.tick  = 12'h000;
          n.pdone = 8'h00;
        end
      end
      PM_BURST: begin
        n.tick = (q.tick == PERIOD_CYC - 12'h001) ? 12'h000 : q.tick + 12'h001; // R2
        n.led  = (n.tick < ON_CYC); // R2
        if (q.tick == PERIOD_CYC - 12'h001) begin
          n.pdone = q.pdone + 8'h01;
          if (q.pdone + 8'h01 == npulse) begin // R1
            n.st         = PM_CONV;
            n.led        = 1'b0;
            n.conv_start = 1'b1;
          end
        end
      end
      PM_CONV: begin
        if (adc.done) begin
          if (raise && q.ctrl.sleep_int && q.ctrl.int_en) begin
            n.st = PM_SLEEP; // R8
          end else if (q.ctrl.wait_en) begin
            n.st     = PM_DWELL; // R9
            n.wtick  = 20'h00000;
            n.wsteps = q.ctrl.wlong ? 12'(wbase * `PM_WLONG_MULT) : wbase;
          end else begin
            n.st    = PM_BURST;
            n.tick  = 12'h000;
            n.pdone = 8'h00;
          end
        end
      end
      PM_DWELL: begin
        n.wtick = (q.wtick == WAIT_STEP_CYC - 20'h00001) ? 20'h00000 : q.wtick + 20'h00001;
        if (q.wtick == WAIT_STEP_CYC - 20'h00001) begin
          n.wsteps = q.wsteps - 12'h001; // R9
          if (q.wsteps == 12'h001) begin
            n.st    = PM_BURST;
            n.tick  = 12'h000;
            n.pdone = 8'h00;
          end
        end
      end
      PM_SLEEP: begin
        // single measurement ends here until the host clears the flag
        if (!q.stat[`PM_ST_PROX]) begin
          n.st    = PM_BURST;
          n.tick  = 12'h000;
          n.pdone = 8'h00;
        end
      end
    endcase
    if (!q.ctrl.en) begin
      n.st  = PM_IDLE;
      n.led = 1'b0;
    end
    // every burst entry lights at tick 0, else the first pulse is one cycle short
    if (n.st == PM_BURST && q.st != PM_BURST) n.led = 1'b1; // R2
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q        <= '0;
      q.st     <= PM_IDLE;
      q.pulses <= `PM_PULSE_RST;
      q.pers   <= `PM_PERS_RST;
    end else begin
      q <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign pready           = psel & penable;
  assign prdata           = q.prdata;
  assign pslverr          = q.pslverr & psel & penable;
  assign conv_start       = q.conv_start;
  assign led_current_sink = q.led;
  assign irq              = q.ctrl.int_en & |(q.stat & q.mask); // R3
  assign int_out          = 1'b0; // R6
  assign int_oe           = irq; // R6

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  localparam int ON_I     = int'(ON_CYC);
  localparam int PERIOD_I = int'(PERIOD_CYC);

  int on_len;
  int gap;
  int pfalls;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      on_len <= 0;
      gap    <= 0;
      pfalls <= 0;
    end else begin
      on_len <= q.led ? on_len + 1 : 0;
      gap    <= (q.led && !n.led) ? 0 : gap + 1;
      pfalls <= (q.st != PM_BURST) ? 0 : (q.led && !n.led) ? pfalls + 1 : pfalls;
    end
  end

  sequence s_led_off;
    // a pulse cut short by disable is not a width fault
    $fell(q.led) && $past(q.ctrl.en);
  endsequence

  chk_led_width: assert property (s_led_off |-> on_len == ON_I) // R2
    else $error("led pulse width wrong");
  chk_led_period: assert property ($rose(q.led) && q.pdone != 8'h00 |-> gap == PERIOD_I - ON_I) // R2
    else $error("led pulse period wrong");
  chk_pulse_count: assert property (q.st == PM_BURST && n.st == PM_CONV |-> pfalls == int'(npulse)) // R1
    else $error("pulse count wrong");
  chk_int_hold: assert property (irq && !clr[`PM_ST_PROX] && !clr[`PM_ST_SAT] && n.mask == q.mask // R3
                                 && n.ctrl == q.ctrl |=> irq)
    else $error("interrupt dropped without clear");
  chk_int_drain: assert property (!int_out && (int_oe == irq)) // R6
    else $error("interrupt pin driven high");
  chk_range_restart: assert property (adc_eval && !out |=> q.pcnt == 4'h0) // R5
    else $error("in-range result kept persistence");
  chk_persist_gate: assert property (adc_eval && out && ({1'b0, q.pcnt} + 5'h01 < {1'b0, req}) // R5
                                     && !q.stat[`PM_ST_PROX] |=> !q.stat[`PM_ST_PROX])
    else $error("interrupt before persistence reached");
  chk_sat_flag: assert property (adc_eval && adc.sat |=> q.stat[`PM_ST_SAT]) // R7
    else $error("saturation not flagged");
  chk_sleep_entry: assert property (raise && q.ctrl.en && q.ctrl.sleep_int && q.ctrl.int_en // R8
                                    |=> q.st == PM_SLEEP)
    else $error("no sleep after interrupt");
  chk_offset_apply: assert property (adc_eval |=> q.data == sub_offs($past(adc.count), $past(q.offs))) // R10
    else $error("offset not applied");
  chk_clear_restart: assert property (clr[`PM_ST_PROX] && q.stat[`PM_ST_PROX] && !adc_eval // R12
                                      |=> q.pcnt == 4'h0)
    else $error("clear did not restart count");

endmodule // pm_measure_ctrl
`default_nettype wire

/* File: logic/pm_pkg.sv */
// Purpose: types shared by the proximity measurement block
// Assumes: nothing
// Notes:   one-hot state codes
package pm_pkg;

  typedef enum logic [4:0] {
    PM_IDLE  = 5'h01,
    PM_BURST = 5'h02,
    PM_CONV  = 5'h04,
    PM_DWELL = 5'h08,
    PM_SLEEP = 5'h10
  } pm_state_t;

  typedef enum logic [6:0] {
    PM_I_IDLE = 7'h01,
    PM_I_ADDR = 7'h02,
    PM_I_AACK = 7'h04,
    PM_I_WR   = 7'h08,
    PM_I_WACK = 7'h10,
    PM_I_RD   = 7'h20,
    PM_I_RACK = 7'h40
  } pm_i2c_state_t;

  typedef struct packed {
    logic wlong;
    logic int_en;
    logic sleep_int;
    logic wait_en;
    logic en;
  } pm_ctrl_t;

  typedef struct packed {
    logic        done;
    logic        sat;
    logic [15:0] count;
  } pm_adc_t;

  typedef struct packed {
    logic       stb;
    logic [7:0] addr;
    logic [7:0] data;
  } pm_bytewr_t;

  typedef struct packed {
    logic [2:0]    scl_s;
    logic [2:0]    sda_s;
    logic          scl_f;
    logic          sda_f;
    pm_i2c_state_t st;
    logic [7:0]    sh;
    logic [3:0]    bits;
    logic [7:0]    ptr;
    logic          first;
    logic          rw;
    logic          drv;
    logic          oe;
    pm_bytewr_t    wr;
  } pm_i2c_q_t;

  typedef struct packed {
    pm_state_t   st;
    pm_ctrl_t    ctrl;
    logic [7:0]  pulses;
    logic [7:0]  wtime;
    logic [7:0]  offs;
    logic [15:0] lthr;
    logic [15:0] hthr;
    logic [15:0] data;
    logic [3:0]  pers;
    logic [3:0]  pcnt;
    logic [1:0]  stat;
    logic [1:0]  mask;
    logic [7:0]  pdone;
    logic [11:0] tick;
    logic [19:0] wtick;
    logic [11:0] wsteps;
    logic        led;
    logic        conv_start;
    logic        pslverr;
    logic [31:0] prdata;
  } pm_core_t;

endpackage

/* File: logic/pm_regs.svh */
// Purpose: register offsets, reset values and timing figures of the proximity block
// Assumes: APB byte addresses, one aligned 32-bit word per register
// Notes:   definitions only
`ifndef PM_REGS_SVH
`define PM_REGS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define PM_CTRL_ADR   8'h00
`define PM_PULSE_ADR  8'h04
`define PM_WAIT_ADR   8'h08
`define PM_LTHR_ADR   8'h0C
`define PM_HTHR_ADR   8'h10
`define PM_OFFS_ADR   8'h14
`define PM_PERS_ADR   8'h18
`define PM_DATA_ADR   8'h1C
`define PM_STAT_ADR   8'h20
`define PM_MASK_ADR   8'h24

// ****************************************
// fields and reset values
// ****************************************
`define PM_ST_PROX    0
`define PM_ST_SAT     1
`define PM_ST_SLEEP   2
`define PM_ST_BUSY    3
`define PM_PULSE_RST  8'h01
`define PM_PERS_RST   4'h1
`define PM_WLONG_MULT 12'h00C
// arbitrary target address
`define PM_I2C_DEV    7'h2A

// ****************************************
// timing
// ****************************************
`define PM_CLK_NS        8
`define PM_LED_PERIOD_NS 16000
`define PM_LED_ON_NS     7200
`define PM_WAIT_STEP_NS  2700000

`endif

/* File: verif/pm_host_model.sv */
// Purpose: I2C bus controller standing in for the host microcontroller
// Assumes: open-drain lines with pull-ups, 125 ns link clock period
// Notes:   clock line stands high between frames
`timescale 1ns/1ps
`default_nettype none
`include "pm_regs.svh"
module pm_host_model (
  // bus lines
  output logic      scl,
  output logic      sda_m,
  input  wire logic sda
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #31.25 sda_m = b[i];
      #31.25 scl = 1'b1;
      #62.5 scl = 1'b0;
    end
    #31.25 sda_m = 1'b1;
    #31.25 scl = 1'b1;
    #31.25 ack = sda;
    #31.25 scl = 1'b0;
  endtask
  // address, pointer, one data byte; host clears a pending interrupt this way
  task automatic wr_reg(input logic [7:0] ptr, input logic [7:0] d, output logic [2:0] acks);
    #62.5 sda_m = 1'b0;
    #62.5 scl = 1'b0;
    put_byte({`PM_I2C_DEV, 1'b0}, acks[2]);
    put_byte(ptr, acks[1]);
    put_byte(d, acks[0]);
    #31.25 sda_m = 1'b0;
    #31.25 scl = 1'b1;
    #62.5 sda_m = 1'b1;
  endtask
  // eight bits from the target, then a nack
  task automatic get_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #31.25 sda_m = 1'b1;
      #31.25 scl = 1'b1;
      #31.25 b[i] = sda;
      #31.25 scl = 1'b0;
    end
    #31.25 sda_m = 1'b1;
    #31.25 scl = 1'b1;
    #62.5 scl = 1'b0;
  endtask
  // pointer write, repeated start, one byte read
  task automatic rd_reg(input logic [7:0] ptr, output logic [7:0] d, output logic [2:0] acks);
    #62.5 sda_m = 1'b0;
    #62.5 scl = 1'b0;
    put_byte({`PM_I2C_DEV, 1'b0}, acks[2]);
    put_byte(ptr, acks[1]);
    #31.25 sda_m = 1'b1;
    #31.25 scl = 1'b1;
    #62.5 sda_m = 1'b0;
    #62.5 scl = 1'b0;
    put_byte({`PM_I2C_DEV, 1'b1}, acks[0]);
    get_byte(d);
    #31.25 sda_m = 1'b0;
    #31.25 scl = 1'b1;
    #62.5 sda_m = 1'b1;
  endtask
endmodule // pm_host_model
`default_nettype wire

/* File: verif/pm_measure_ctrl_tb_top.sv */
// Purpose: self-checking bench of the proximity measurement block
// Assumes: short wait step, front end answers one cycle after conv_start
// Notes:   flags are sampled on the falling edge, inputs driven on the rising
`timescale 1ns/1ps
`default_nettype none
`include "pm_regs.svh"
module pm_measure_ctrl_tb_top import pm_pkg::*; ;
  localparam logic [19:0] STEP = 20'h00014;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, scl, sda_m, sda_w, sda_o, sda_oe, conv_start, led, int_out, int_oe, irq;
  pm_adc_t adc = '0;
  logic [15:0] cnt_v = 16'h0;
  logic sat_v = 1'b0;
  int num_errors = 0;
  int n_checks = 0;
  always #4 clk = ~clk;
  // front end answers each conversion request
  always @(posedge clk) begin
    adc <= '{done: (conv_start === 1'b1), sat: sat_v, count: cnt_v};
  end
  assign sda_w = sda_m & (sda_o | ~sda_oe);
  pm_measure_ctrl #(.WAIT_STEP_CYC(STEP)) pm_measure_ctrl_inst (.clk(clk), .rst(rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o), .sda_oe(sda_oe), .adc(adc),
    .conv_start(conv_start), .led_current_sink(led), .int_out(int_out), .int_oe(int_oe), .irq(irq));
  pm_host_model pm_host_model_inst (.scl(scl), .sda_m(sda_m), .sda(sda_w));
  // ****************************************
  // shared tasks
  // ****************************************
  task end_sim;
    if (num_errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      num_errors++;
      end_sim();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r & m, exp);
  endtask
  task wait_conv(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (conv_start !== 1'b1 && n < 30000);
    if (n >= 30000) begin
      num_errors++;
      end_sim();
    end
  endtask
  task meas(input logic [15:0] c, input logic s);
    int n;
    cnt_v = c;
    sat_v = s;
    wait_conv(n);
    repeat (4) @(negedge clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    logic [31:0] r;
    logic e;
    rdm(`PM_PULSE_ADR, 32'hFFFFFFFF, 32'h1);
    rdm(`PM_PERS_ADR, 32'hFFFFFFFF, 32'h1);
    apb(1'b0, 8'h28, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
  endtask
  task t_burst;
    int n, hi, rs, t1, gap;
    logic prev;
    wr(`PM_PULSE_ADR, 32'h3);
    wr(`PM_CTRL_ADR, 32'h1);
    n = 0; hi = 0; rs = 0; t1 = 0; gap = 0; prev = 1'b0;
    while (conv_start !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n++;
      if (led === 1'b1) hi++;
      if (led === 1'b1 && !prev) begin
        rs++;
        if (rs == 1) t1 = n;
        if (rs == 2) gap = n - t1;
      end
      prev = (led === 1'b1);
    end
    chk(32'(rs), 32'h3);
    chk(32'(hi), 32'hA8C);
    chk(32'(gap), 32'h7D0);
  endtask
  task t_wait;
    int n, g0, g1;
    wr(`PM_PULSE_ADR, 32'h1);
    wr(`PM_WAIT_ADR, 32'h1);
    wait_conv(n);
    wait_conv(g0);
    wr(`PM_CTRL_ADR, 32'h3);
    wait_conv(n);
    wait_conv(g1);
    chk(32'(g1 - g0), 32'h28);
    wr(`PM_CTRL_ADR, 32'h13);
    wait_conv(n);
    wait_conv(g1);
    chk(32'(g1 - g0), 32'h1E0);
    wr(`PM_CTRL_ADR, 32'h0);
  endtask
  task t_thresh;
    wr(`PM_STAT_ADR, 32'h3);
    wr(`PM_LTHR_ADR, 32'h64);
    wr(`PM_HTHR_ADR, 32'hC8);
    wr(`PM_OFFS_ADR, 32'hA);
    wr(`PM_PERS_ADR, 32'h2);
    wr(`PM_MASK_ADR, 32'h1);
    wr(`PM_CTRL_ADR, 32'h9);
    meas(16'h0104, 1'b0);
    rdm(`PM_DATA_ADR, 32'hFFFFFFFF, 32'hFA);
    meas(16'h00D2, 1'b0);
    chk(32'(irq), 32'h0);
    meas(16'h003C, 1'b0);
    chk(32'(irq), 32'h0);
    meas(16'h0005, 1'b0);
    chk({29'h0, int_out, int_oe, irq}, 32'h3);
    rdm(`PM_DATA_ADR, 32'hFFFFFFFF, 32'h0);
    meas(16'h006E, 1'b1);
    chk(32'(irq), 32'h1);
    rdm(`PM_STAT_ADR, 32'h3, 32'h3);
    wr(`PM_STAT_ADR, 32'h1);
    @(negedge clk);
    chk({30'h0, int_out, int_oe}, 32'h0);
    meas(16'h0005, 1'b0);
    chk(32'(irq), 32'h0);
    wr(`PM_CTRL_ADR, 32'h0);
  endtask
  task t_sleep;
    int n, seen;
    logic [2:0] acks;
    logic [7:0] d;
    wr(`PM_STAT_ADR, 32'h3);
    wr(`PM_PERS_ADR, 32'h1);
    wr(`PM_CTRL_ADR, 32'hD);
    meas(16'h0005, 1'b0);
    rdm(`PM_STAT_ADR, 32'h5, 32'h5);
    seen = 0;
    for (n = 0; n < 4000; n++) begin
      @(negedge clk);
      if (conv_start !== 1'b0) seen++;
    end
    chk(32'(seen), 32'h0);
    pm_host_model_inst.wr_reg(`PM_STAT_ADR, 8'h01, acks);
    chk({29'h0, acks}, 32'h0);
    @(negedge clk);
    chk(32'(irq), 32'h0);
    rdm(`PM_STAT_ADR, 32'h5, 32'h0);
    pm_host_model_inst.rd_reg(`PM_LTHR_ADR, d, acks);
    chk({21'h0, acks, d}, 32'h64);
    wr(`PM_CTRL_ADR, 32'h0);
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_burst();
    t_wait();
    t_thresh();
    t_sleep();
    end_sim();
  end
endmodule // pm_measure_ctrl_tb_top
`default_nettype wire
